// file: hdl/charge_cycle_pkg.sv
// Behaviour
// R1: Input overload engages the input current or input voltage limit loop.
// R2: System rail below minimum during charging lets the minimum loop cut charge current.
// R3: Zero charge current and rail below battery enters supplement mode, switch on.
// R4: Supplement mode drives the battery switch as an ideal diode, about 25 mV drop.
// R5: Battery below depletion threshold ends supplement mode, switch off.
// R6: Each active input limit loop sets its own status flag; both may be set.
// R7: Enable bit 1 and enable pin low run a full cycle; host may reprogram anytime.
// R8: Default voltage target 4.2, 8.4, 12.6 or 16.8 V by cell count.
// R9: Default currents: fast 2 A or 1 A, pre 120 mA, trickle 100 mA, term 200 mA.
// R10: Default timers 12 h fast, 2 h pre, 1 h trickle; recharge offset 200 mV.
// R11: New cycle needs converter up, both enables, no thermistor or timer fault.
// R12: Terminate when current below threshold and battery above recharge level, unless limiting.
// R13: After termination, battery below recharge threshold restarts; 2-bit offset select.
// R14: Toggling the enable pin or the enable bit after termination restarts a cycle.
// R15: Indicator low while charging, high when done or disabled, blinking on fault.
// R16: Indicator disable bit set stops driving the indicator pin.
// R17: Phase code 000 idle, 001 trickle, 010 pre, 011 CC, 100 CV, 110 top-off, 111 done.
// R18: Every phase code change raises an interrupt.
// R19: Cycle start picks trickle, pre-charge or fast charge from battery voltage.
// R20: Limiting or thermal regulation suppresses termination and halves the safety timer rate.
// R21: Linear mode disabled moves pre and fast current to converter loop, no minimum hold.
// R22: Fast entry threshold is a ratio of the target; trickle exit fixed at 2.2 V.
// R23: Charge interrupt mask set suppresses every charge cycle interrupt pulse.
// R24: Each interrupt is one active-low pulse of fixed length per event; code merges a change during a pulse into one longer pulse.
// R25: Fault blink toggles at a fixed period for as long as the fault lasts.
package charge_cycle_pkg;
  // Clock
  localparam int unsigned CLK_HZ         = 20000000;
  // Voltages in mV, currents in mA
  localparam logic [15:0] CHARGE_VOLTAGE_TARGET_1S_MV     = 16'd4200;
  localparam logic [15:0] CHARGE_VOLTAGE_TARGET_2S_MV     = 16'd8400;
  localparam logic [15:0] CHARGE_VOLTAGE_TARGET_3S_MV     = 16'd12600;
  localparam logic [15:0] CHARGE_VOLTAGE_TARGET_4S_MV     = 16'd16800;
  localparam logic [15:0] TRICKLE_EXIT_MV = 16'd2200;
  localparam logic [15:0] RECHG_BASE_MV  = 16'd200;
  localparam logic [15:0] FAST_CHARGE_CURRENT_LOW_MA    = 16'd2000;
  localparam logic [15:0] FAST_CHARGE_CURRENT_HIGH_MA   = 16'd1000;
  localparam logic [15:0] IPRE_MA        = 16'd120;
  localparam logic [15:0] ITRICKLE_MA    = 16'd100;
  localparam logic [15:0] ITERM_MA       = 16'd200;
  localparam logic [15:0] DIODE_DROP_MV  = 16'd25;
  // Fast entry ratio in 1/16 of target
  localparam logic [4:0]  LOWV_RATIO_16  = 5'd11;
  // Timers in seconds
  localparam int unsigned TMR_FAST_S     = 43200;
  localparam int unsigned TMR_PRE_S      = 7200;
  localparam int unsigned TMR_TRICKLE_S  = 3600;
  // Pulse and blink
  localparam int unsigned INT_PULSE_NS   = 256000;
  localparam int unsigned INT_PULSE_CYC  = INT_PULSE_NS / (1000000000 / CLK_HZ);
  localparam int unsigned BLINK_MS       = 500;
  localparam int unsigned BLINK_CYC      = BLINK_MS * (CLK_HZ / 1000);
  localparam int unsigned SECOND_CYC     = CLK_HZ;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [7:0]  SETTINGS_OFS   = 8'h08;
  localparam logic [7:0]  TERM_OFS       = 8'h0c;
  // Control bit positions
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_STATDIS_BIT = 1;
  localparam int CTRL_LINDIS_BIT = 2;
  localparam int CTRL_MASK_BIT   = 3;
  localparam int CTRL_RECHG_LSB  = 4;
  localparam int CTRL_CELLS_LSB  = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  typedef enum logic [2:0] {
    PH_IDLE    = 3'b000,
    PH_TRICKLE = 3'b001,
    PH_PRE     = 3'b010,
    PH_CC      = 3'b011,
    PH_CV      = 3'b100,
    PH_RSVD    = 3'b101,
    PH_TOPOFF  = 3'b110,
    PH_DONE    = 3'b111
  } phase_e;
endpackage

// file: hdl/charge_cycle_controller.sv
module charge_cycle_controller
  import charge_cycle_pkg::*;
#(
  parameter int unsigned SECOND_CYCLES = SECOND_CYC,
  parameter int unsigned BLINK_CYCLES  = BLINK_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Analog measurements, mV and mA
  input  wire logic [15:0] vbat_mv_i,
  input  wire logic [15:0] vsys_mv_i,
  input  wire logic [15:0] fast_charge_current_ma_i,
  input  wire logic [15:0] min_system_voltage_mv_i,
  input  wire logic [15:0] vdeplete_mv_i,
  // Comparator and status inputs
  input  wire logic        input_overload_i,
  input  wire logic        input_voltage_low_i,
  input  wire logic        converter_up_i,
  input  wire logic        thermal_reg_i,
  input  wire logic        thermistor_fault_i,
  input  wire logic        charge_enable_n_i,
  // Loop controls
  output logic             input_current_limit_loop_o,
  output logic             input_voltage_limit_loop_o,
  output logic             min_sys_loop_o,
  output logic             converter_current_loop_o,
  output logic             battery_switch_o,
  output logic             ideal_diode_o,
  output logic      [15:0] diode_drop_mv_o,
  output logic      [15:0] charge_current_ma_o,
  output logic      [15:0] charge_voltage_mv_o,
  // Indicator pin and interrupt
  output logic             stat_o,
  output logic             stat_oe_n_o,
  output logic             int_n_o
);

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] term_ma;
    logic [31:0] dat;
    logic        ack;
    phase_e      phase;
    logic        supplement;
    logic        en_sync1;
    logic        en_sync2;
    logic        en_prev;
    logic        timer_fault;
    logic [31:0] tick_cnt;
    logic        half_tog;
    logic [31:0] sec_cnt;
    logic [31:0] blink_cnt;
    logic        blink;
    logic [31:0] pulse_cnt;
  } state_s;

  state_s s_reg;
  state_s s_next;

  logic        en_bit;
  logic        enabled;
  logic        limiting;
  logic        can_start;
  logic [15:0] charge_voltage_target_mv;
  logic [15:0] lowv_mv;
  logic [15:0] rechg_mv;
  logic [20:0] lowv_wide;
  logic [31:0] limit_s;
  phase_e      start_phase;
  logic        wr_ctrl;
  logic        wr_term;

  assign en_bit  = s_reg.ctrl[CTRL_EN_BIT];
  assign enabled = en_bit && !s_reg.en_sync2;
  assign limiting = input_overload_i || input_voltage_low_i || thermal_reg_i;
  assign wr_ctrl = cyc_i && stb_i && we_i && !s_reg.ack && adr_i == CTRL_OFS;
  assign wr_term = cyc_i && stb_i && we_i && !s_reg.ack && adr_i == TERM_OFS;

  ////////////////////////////////////////////////////////////////////////
  // Thresholds

  // R8 target by cells
  always_comb begin
    unique case (s_reg.ctrl[CTRL_CELLS_LSB +: 2])
      2'd0: charge_voltage_target_mv = CHARGE_VOLTAGE_TARGET_1S_MV;
      2'd1: charge_voltage_target_mv = CHARGE_VOLTAGE_TARGET_2S_MV;
      2'd2: charge_voltage_target_mv = CHARGE_VOLTAGE_TARGET_3S_MV;
      2'd3: charge_voltage_target_mv = CHARGE_VOLTAGE_TARGET_4S_MV;
    endcase
  end

  // R22 fast entry ratio
  assign lowv_wide = ({5'd0, charge_voltage_target_mv} * {16'd0, LOWV_RATIO_16}) >> 4;
  assign lowv_mv   = lowv_wide[15:0];
  // R13 offset select, 200 mV steps from the default
  assign rechg_mv  = charge_voltage_target_mv - RECHG_BASE_MV * ({14'd0, s_reg.ctrl[CTRL_RECHG_LSB +: 2]} + 16'd1);

  // R19 phase from battery voltage
  always_comb begin
    if (vbat_mv_i < TRICKLE_EXIT_MV) begin
      start_phase = PH_TRICKLE;
    end else if (vbat_mv_i < lowv_mv) begin
      start_phase = PH_PRE;
    end else begin
      start_phase = PH_CC;
    end
  end

  // R11 start conditions
  assign can_start = converter_up_i && enabled && !thermistor_fault_i && !s_reg.timer_fault;

  // R10 default timer limits
  always_comb begin
    unique case (s_reg.phase)
      PH_TRICKLE: limit_s = TMR_TRICKLE_S;
      PH_PRE:     limit_s = TMR_PRE_S;
      default:    limit_s = TMR_FAST_S;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_next = s_reg;
    s_next.ack = cyc_i && stb_i && !s_reg.ack;
    // Pin crosses in from outside, two flops first
    s_next.en_sync1 = charge_enable_n_i;
    s_next.en_sync2 = s_reg.en_sync1;
    s_next.en_prev  = enabled;

    // R7 host rewrites settings anytime
    if (wr_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          s_next.ctrl[8*b +: 8] = dat_i[8*b +: 8];
        end
      end
    end
    if (wr_term && sel_i[0]) begin
      s_next.term_ma[7:0] = dat_i[7:0];
    end
    if (wr_term && sel_i[1]) begin
      s_next.term_ma[15:8] = dat_i[15:8];
    end

    s_next.dat = 32'h0000_0000;
    if (cyc_i && stb_i && !we_i && !s_reg.ack) begin
      unique case (adr_i)
        CTRL_OFS:     s_next.dat = s_reg.ctrl;
        STATUS_OFS:   s_next.dat = {24'h00_0000, s_reg.timer_fault, s_reg.supplement,
                                    input_voltage_low_i, input_overload_i, 1'b0, s_reg.phase};
        SETTINGS_OFS: s_next.dat = {charge_voltage_target_mv, lowv_mv};
        TERM_OFS:     s_next.dat = {16'h0000, s_reg.term_ma};
        default:      s_next.dat = 32'h0000_0000;
      endcase
    end

    // Safety timer, halved rate while limiting
    s_next.tick_cnt = s_reg.tick_cnt + 32'd1;
    if (s_reg.tick_cnt >= SECOND_CYCLES - 1) begin
      s_next.tick_cnt = 32'd0;
      s_next.half_tog = ~s_reg.half_tog;
      // R20 half rate count
      if (s_reg.phase inside {PH_TRICKLE, PH_PRE, PH_CC, PH_CV} && !s_reg.supplement &&
          (!limiting || s_reg.half_tog)) begin
        s_next.sec_cnt = s_reg.sec_cnt + 32'd1;
        if (s_reg.sec_cnt + 32'd1 >= limit_s) begin
          s_next.timer_fault = 1'b1;
        end
      end
    end

    // R17 phase machine codes
    unique case (s_reg.phase)
      PH_IDLE, PH_RSVD: begin
        if (can_start) begin
          s_next.phase   = start_phase;
          s_next.sec_cnt = 32'd0;
        end
      end
      PH_TRICKLE, PH_PRE, PH_CC, PH_CV: begin
        if (start_phase != s_reg.phase && s_reg.phase != PH_CV && start_phase != PH_CC) begin
          s_next.phase   = start_phase;
          s_next.sec_cnt = 32'd0;
        end else if (s_reg.phase == PH_CC && start_phase == PH_CC && vbat_mv_i >= charge_voltage_target_mv) begin
          s_next.phase = PH_CV;
        end else if (s_reg.phase == PH_PRE && start_phase == PH_CC) begin
          s_next.phase   = PH_CC;
          s_next.sec_cnt = 32'd0;
        end
        // R12 termination, R20 suppressed while limiting
        if (s_reg.phase inside {PH_CC, PH_CV} && fast_charge_current_ma_i < s_reg.term_ma &&
            vbat_mv_i > rechg_mv && !limiting) begin
          s_next.phase = PH_DONE;
        end
      end
      PH_TOPOFF: s_next.phase = PH_DONE;
      PH_DONE: begin
        // R13 recharge restart
        if (vbat_mv_i < rechg_mv && can_start) begin
          s_next.phase   = start_phase;
          s_next.sec_cnt = 32'd0;
        end
      end
    endcase
    if (!enabled || !can_start && s_reg.phase != PH_DONE) begin
      s_next.phase = PH_IDLE;
    end
    // R14 toggle of pin or bit restarts from idle
    if (enabled && !s_reg.en_prev) begin
      s_next.timer_fault = 1'b0;
      s_next.sec_cnt     = 32'd0;
    end

    // R3 enter supplement, R5 leave it
    // Depleted battery may not re-enter, or the switch would chatter each cycle
    if (!s_reg.supplement && fast_charge_current_ma_i == 16'd0 && vsys_mv_i < vbat_mv_i &&
        vbat_mv_i >= vdeplete_mv_i) begin
      s_next.supplement = 1'b1;
    end else if (s_reg.supplement && vbat_mv_i < vdeplete_mv_i) begin
      s_next.supplement = 1'b0;
    end

    // R25 fault blink period
    s_next.blink_cnt = s_reg.blink_cnt + 32'd1;
    if (s_reg.blink_cnt >= BLINK_CYCLES - 1) begin
      s_next.blink_cnt = 32'd0;
      s_next.blink     = ~s_reg.blink;
    end

    // R18 change raises interrupt, R23 masked, R24 fixed pulse
    if (s_reg.pulse_cnt != 32'd0) begin
      s_next.pulse_cnt = s_reg.pulse_cnt - 32'd1;
    end
    if (s_next.phase != s_reg.phase && !s_reg.ctrl[CTRL_MASK_BIT]) begin
      s_next.pulse_cnt = INT_PULSE_CYC;
    end

    if (rst_i) begin
      s_next = '0;
      s_next.ctrl     = CTRL_RESET;
      s_next.term_ma  = ITERM_MA;
      s_next.en_sync1 = 1'b1;
      s_next.en_sync2 = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dat_o = s_reg.dat;
  assign ack_o = s_reg.ack;

  // R1 limit loops, R6 flags follow the same levels
  assign input_current_limit_loop_o = input_overload_i;
  assign input_voltage_limit_loop_o = input_voltage_low_i;
  // R2 minimum loop, R21 dropped outside trickle when linear mode off
  assign min_sys_loop_o = s_reg.phase inside {PH_TRICKLE, PH_PRE, PH_CC, PH_CV} &&
                          vsys_mv_i < min_system_voltage_mv_i &&
                          (!s_reg.ctrl[CTRL_LINDIS_BIT] || s_reg.phase == PH_TRICKLE);
  // R21 converter regulates pre and fast current
  assign converter_current_loop_o = s_reg.ctrl[CTRL_LINDIS_BIT] &&
                                    s_reg.phase inside {PH_PRE, PH_CC};
  // R4 ideal diode in supplement
  assign ideal_diode_o   = s_reg.supplement;
  assign diode_drop_mv_o = s_reg.supplement ? DIODE_DROP_MV : 16'h0000;
  assign battery_switch_o = s_reg.supplement ||
                            s_reg.phase inside {PH_TRICKLE, PH_PRE, PH_CC, PH_CV, PH_TOPOFF};

  // R9 default currents
  always_comb begin
    unique case (s_reg.phase)
      PH_TRICKLE: charge_current_ma_o = ITRICKLE_MA;
      PH_PRE:     charge_current_ma_o = IPRE_MA;
      PH_CC, PH_CV, PH_TOPOFF:
        charge_current_ma_o = s_reg.ctrl[CTRL_CELLS_LSB + 1] ? FAST_CHARGE_CURRENT_HIGH_MA : FAST_CHARGE_CURRENT_LOW_MA;
      default:    charge_current_ma_o = 16'h0000;
    endcase
  end
  assign charge_voltage_mv_o = charge_voltage_target_mv;

  // R15 indicator levels, R16 pin released when disabled
  assign stat_o      = s_reg.timer_fault || thermistor_fault_i ? s_reg.blink :
                       !(s_reg.phase inside {PH_TRICKLE, PH_PRE, PH_CC, PH_CV, PH_TOPOFF});
  assign stat_oe_n_o = s_reg.ctrl[CTRL_STATDIS_BIT];
  // R24 active-low pulse
  assign int_n_o = s_reg.pulse_cnt == 32'd0;

endmodule

// file: verification/charge_cycle_asserts.sv
module charge_cycle_asserts
  import charge_cycle_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  // Power path and interrupt
  input wire logic        input_overload_i,
  input wire logic        input_voltage_low_i,
  input wire logic        input_current_limit_loop_o,
  input wire logic        input_voltage_limit_loop_o,
  input wire logic        battery_switch_o,
  input wire logic        ideal_diode_o,
  input wire logic [15:0] diode_drop_mv_o,
  input wire logic        int_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] low_reg;

  // Length of the current low run of the interrupt pin
  always_ff @(posedge clk_i) begin
    if (rst_i || int_n_o) begin
      low_reg <= '0;
    end else begin
      low_reg <= low_reg + 32'h1;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_once;
    ack_o |=> !ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_due;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_due: assert property (p_ack_due) else $error("ack late");
  property p_ack_cause;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_iin_flag;
    input_current_limit_loop_o == input_overload_i;
  endproperty
  a_iin_flag: assert property (p_iin_flag) else $error("current loop wrong");
  property p_vin_flag;
    input_voltage_limit_loop_o == input_voltage_low_i;
  endproperty
  a_vin_flag: assert property (p_vin_flag) else $error("voltage loop wrong");
  property p_drop;
    diode_drop_mv_o == (ideal_diode_o ? DIODE_DROP_MV : 16'h0);
  endproperty
  a_drop: assert property (p_drop) else $error("diode drop wrong");
  property p_diode_sw;
    ideal_diode_o |-> battery_switch_o;
  endproperty
  a_diode_sw: assert property (p_diode_sw) else $error("diode with switch off");
  property p_int_len;
    $rose(int_n_o) |-> low_reg >= INT_PULSE_CYC;
  endproperty
  a_int_len: assert property (p_int_len) else $error("interrupt pulse short");
endmodule

bind charge_cycle_controller charge_cycle_asserts chk_u (
  .clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .input_overload_i, .input_voltage_low_i,
  .input_current_limit_loop_o, .input_voltage_limit_loop_o, .battery_switch_o,
  .ideal_diode_o, .diode_drop_mv_o, .int_n_o
);

// file: verification/host_bus_model.sv
module host_bus_model (
  // Clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  // Request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic      [7:0]  adr_o,
  output logic      [3:0]  sel_o,
  output logic      [31:0] dat_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // Request held until ack is sampled, so no hold-time guess
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hf, d};
    do @(posedge clk_i); while (ack_i !== 1'b1);
    {cyc_o, stb_o} <= 2'b00;
  endtask
  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic wb_read(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
endmodule

// file: verification/tb_charge_cycle_controller.sv
module tb_charge_cycle_controller
  import charge_cycle_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cyc, stb, we, ack, ovl, vlow, conv, treg, tfault, cen_n;
  logic iinl, vinl, msl, ccl, bsw, idd, stat, stat_oe_n, int_n, prev;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [15:0] vbat, vsys, fast_charge_current, vmin, vdep, drop, icur, vtgt;
  logic [63:0] notes[$];
  logic [15:0] tg[4] = '{CHARGE_VOLTAGE_TARGET_1S_MV, CHARGE_VOLTAGE_TARGET_2S_MV, CHARGE_VOLTAGE_TARGET_3S_MV, CHARGE_VOLTAGE_TARGET_4S_MV};
  logic [15:0] vb[3] = '{16'h07d0, 16'h09c4, 16'h0dac};
  logic [15:0] cu[3] = '{ITRICKLE_MA, IPRE_MA, FAST_CHARGE_CURRENT_LOW_MA};
  int mismatches = 0, n_checks = 0, cnt;

  initial forever #25 clk = ~clk;

  charge_cycle_controller #(.SECOND_CYCLES(10), .BLINK_CYCLES(4)) dut_u (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .vbat_mv_i(vbat), .vsys_mv_i(vsys),
    .fast_charge_current_ma_i(fast_charge_current), .min_system_voltage_mv_i(vmin), .vdeplete_mv_i(vdep), .input_overload_i(ovl),
    .input_voltage_low_i(vlow), .converter_up_i(conv), .thermal_reg_i(treg),
    .thermistor_fault_i(tfault), .charge_enable_n_i(cen_n), .input_current_limit_loop_o(iinl),
    .input_voltage_limit_loop_o(vinl), .min_sys_loop_o(msl), .converter_current_loop_o(ccl),
    .battery_switch_o(bsw), .ideal_diode_o(idd), .diode_drop_mv_o(drop),
    .charge_current_ma_o(icur), .charge_voltage_mv_o(vtgt), .stat_o(stat),
    .stat_oe_n_o(stat_oe_n), .int_n_o(int_n));
  host_bus_model host_u (.clk_i(clk), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic [15:0] got, input logic [15:0] exp);
    cmp_word({16'h0, got}, {16'h0, exp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e});
    host_u.wb_read(a);
  endtask
  task automatic nap(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && n_checks > 0 && notes.size() == 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Read data is judged at the ack edge against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      cmp_word(rdat & notes[0][63:32], notes[0][31:0]);
      void'(notes.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {vbat, vsys, vmin, vdep} = {16'h0dac, 16'h0e74, 16'h0ce4, 16'h0a28};
    {ovl, vlow, conv, treg, tfault, cen_n} = 6'b001000;
    void'($urandom(32'h739d));
    fast_charge_current = 16'h012c + 16'($urandom % 1000);
    nap(5);
    rst <= 0;
    rd(CTRL_OFS, CTRL_RESET, '1);
    rd(TERM_OFS, 32'(ITERM_MA), '1);
    rd(8'h10, 32'h0, '1);
    host_u.wb_write(TERM_OFS, 32'h12c);
    rd(TERM_OFS, 32'h12c, '1);
    host_u.wb_write(TERM_OFS, 32'(ITERM_MA));
    cmp_pin(vtgt, CHARGE_VOLTAGE_TARGET_1S_MV);
    for (int c = 0; c < 4; c++) begin
      host_u.wb_write(CTRL_OFS, 32'(c << 6) | 32'h8);
      rd(SETTINGS_OFS, {tg[c], 16'((32'(tg[c]) * 11) / 16)}, '1);
    end
    for (int i = 0; i < 3; i++) begin
      {vbat, vsys} <= {vb[i], 16'h0c80};
      host_u.wb_write(CTRL_OFS, 32'h0);
      host_u.wb_write(CTRL_OFS, (i == 1) ? 32'h5 : 32'h1);
      nap(4);
      rd(STATUS_OFS, 32'(i + 1), 32'hf7);
      cmp_pin(icur, cu[i]);
      cmp_pin({15'h0, stat}, 16'h0);
      cmp_pin({15'h0, int_n}, 16'h0);
      cmp_pin({15'h0, msl}, {15'h0, i != 1});
      cmp_pin({15'h0, ccl}, {15'h0, i == 1});
    end
    {ovl, vlow, vbat, fast_charge_current, vsys} <= {2'b11, 16'h1004, 16'h0064, 16'h0e74};
    nap(4);
    rd(STATUS_OFS, 32'h33, 32'hf7);
    {ovl, vlow} <= 2'b00;
    nap(4);
    rd(STATUS_OFS, 32'h07, 32'hf7);
    cmp_pin({15'h0, stat}, 16'h1);
    {vbat, fast_charge_current} <= {16'h0f3c, 16'h01f4};
    nap(4);
    rd(STATUS_OFS, 32'h03, 32'hf7);
    while (int_n !== 1'b1) @(posedge clk);
    host_u.wb_write(CTRL_OFS, 32'h8);
    cnt = 0;
    repeat (10) begin
      @(posedge clk);
      if (int_n !== 1'b1) cnt++;
    end
    cmp_pin(16'(cnt), 16'h0);
    {vsys, fast_charge_current} <= {16'h0d48, 16'h0};
    nap(4);
    cmp_pin({15'h0, bsw}, 16'h1);
    rd(STATUS_OFS, 32'h40, 32'h47);
    cmp_pin(drop, DIODE_DROP_MV);
    vdep <= 16'h0fa0;
    nap(4);
    cmp_pin({15'h0, bsw}, 16'h0);
    {vdep, vsys, fast_charge_current} <= {16'h0a28, 16'h0fa0, 16'h01f4};
    host_u.wb_write(CTRL_OFS, 32'h2);
    nap(2);
    cmp_pin({15'h0, stat_oe_n}, 16'h1);
    tfault <= 1;
    host_u.wb_write(CTRL_OFS, 32'h1);
    nap(4);
    rd(STATUS_OFS, 32'h0, 32'h7);
    cnt = 0;
    prev = stat;
    repeat (24) begin
      @(posedge clk);
      if (stat !== prev) cnt++;
      prev = stat;
    end
    cmp_pin(16'(cnt), 16'h0006);
    tfault <= 0;
    nap(4);
    rd(STATUS_OFS, 32'h3, 32'h7);
    cen_n <= 1;
    nap(6);
    rd(STATUS_OFS, 32'h0, 32'h7);
    cmp_pin({15'h0, stat}, 16'h1);
    cen_n <= 0;
    nap(6);
    rd(STATUS_OFS, 32'h3, 32'h7);
    nap(2);
    end_of_test();
  end
endmodule
